// file: hdl/crs_pkg.sv
// Constants, encodings and types shared by the core register set
package crs_pkg;
  // Condition flag field positions
  localparam int BIT_C = 0;
  localparam int BIT_Z = 1;
  localparam int BIT_N = 2;
  localparam int BIT_PLO = 3;
  localparam int BIT_H = 4;
  localparam int BIT_PHI = 5;
  localparam int BIT_SIGN = 7;
  // Reset values and masks
  localparam logic [7:0] FLAGS_RESET = 8'h28;
  localparam logic [7:0] FLAGS_MASK = 8'h3F;
  localparam logic [7:0] SP_RESET_LOW = 8'hFF;
  localparam logic [7:0] STACK_HIGH = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [7:0] SP_STEP = 8'h01;
  // Priority codes {high bit, low bit}
  localparam logic [1:0] PRIO_LEVEL0 = 2'h2;
  localparam logic [1:0] PRIO_LEVEL1 = 2'h1;
  localparam logic [1:0] PRIO_LEVEL2 = 2'h0;
  localparam logic [1:0] PRIO_LEVEL3 = 2'h3;
  // Stack frame lengths minus one
  localparam logic [2:0] INT_LAST = 3'h4;
  localparam logic [2:0] CALL_LAST = 3'h1;
  localparam logic [2:0] ONE_LAST = 3'h0;
  localparam logic [2:0] STEP_ONE = 3'h1;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_LOAD_A = 5'h01, OP_LOAD_IDX = 5'h02, OP_ALU = 5'h03,
    OP_SET_C = 5'h04, OP_CLR_C = 5'h05, OP_FLAG_WR = 5'h06, OP_MASK_SET = 5'h07,
    OP_MASK_RST = 5'h08, OP_WAIT = 5'h09, OP_PREFIX = 5'h0A, OP_PUSH = 5'h0B,
    OP_POP = 5'h0C, OP_CALL = 5'h0D, OP_RET = 5'h0E, OP_INT = 5'h0F,
    OP_INTERRUPT_RETURN = 5'h10, OP_RSP = 5'h11, OP_LD_SP = 5'h12, OP_JUMP = 5'h13,
    OP_PC_INC = 5'h14
  } crs_op_type;

  typedef enum logic [2:0] {
    ITEM_PCL = 3'h0, ITEM_PCH = 3'h1, ITEM_X = 3'h2, ITEM_A = 3'h3, ITEM_CC = 3'h4, ITEM_Y = 3'h5
  } crs_item_type;

  typedef enum logic [1:0] {SEQ_ONE = 2'h0, SEQ_CALL = 2'h1, SEQ_INT = 2'h2} crs_seq_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_PUSH = 4'h2, ST_POP_RD = 4'h4, ST_POP_WR = 4'h8
  } crs_state_type;
endpackage

// file: hdl/crs_stack_if.sv
// Port bundle between the register set and its stack memory
`timescale 1ns/1ns
interface crs_stack_if;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  modport ctrl (output wr_en, output rd_en, output addr, output wr_data, input rd_data);
  modport mem (input wr_en, input rd_en, input addr, input wr_data, output rd_data);
endinterface

// file: hdl/crs_stack_mem.sv
// 256-byte stack memory with registered read data
`timescale 1ns/1ns
module crs_stack_mem (
  input wire logic clk_sys,
  input wire logic reset_n,
  crs_stack_if.mem stk
);
  logic [7:0] mem_q [0:255];
  logic [7:0] rd_q;

  // Storage has no reset; contents are undefined until pushed
  always_ff @(posedge clk_sys) begin
    if (stk.wr_en) begin
      mem_q[stk.addr] <= stk.wr_data;
    end
  end

  // Read data appear one cycle after the read strobe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_q <= crs_pkg::BYTE_ZERO;
    end else if (stk.rd_en) begin
      rd_q <= mem_q[stk.addr];
    end
  end

  assign stk.rd_data = rd_q;
endmodule

// file: hdl/crs_core_regs.sv
// Core register set: accumulator, index pair, program counter, flags and stack pointer
// Operation
// - Registers sit outside the memory map; only dedicated ops reach them.
// - Accumulator is eight bits, takes operands and ALU results.
// - Two eight-bit index registers; a prefix op redirects the next to the second.
// - Interrupt entry and return never touch the second index register.
// - Program counter is sixteen bits, built of low and high byte.
// - Half carry in bit 4 follows carry out of bit 3 on adds.
// - Negative flag in bit 2 copies result bit 7.
// - Zero flag in bit 1 set when result is zero, else cleared.
// - Carry flag in bit 0 shows overflow or underflow of last arithmetic.
// - Set and clear carry ops force carry; tests, shifts, rotates update it.
// - Flags can be pushed, popped, and each bit tested or written.
// - Priority bits 5 and 3 encode levels 0 to 3; 11 disables interrupts.
// - Interrupt entry loads priority bits from the serviced source's level.
// - Mask set, mask reset, return, halt, wait and pop also write priority; the code has no halt op, and plain return leaves priority.
// - Stack pointer names next free byte; push then decrement, increment then pop.
// - Stack is 256 bytes; upper stack pointer byte fixed by hardware.
// - Reset or stack reset op sets all low stack pointer bits.
// - Stack pointer wraps silently past either limit.
// - Load op reads and writes stack pointer low byte directly.
// - Interrupt pushes program counter low first, rest at lower addresses.
// - Call uses two stack bytes; interrupt uses five.
`timescale 1ns/1ns
module crs_core_regs (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic op_valid,
  input wire crs_pkg::crs_op_type op_code,
  input wire logic [7:0] op_data,
  input wire logic [15:0] op_addr,
  input wire logic [7:0] alu_result,
  input wire logic alu_carry,
  input wire logic alu_half,
  input wire logic alu_carry_en,
  input wire logic alu_half_en,
  input wire logic [1:0] int_level,
  output logic [7:0] accumulator_q,
  output logic [7:0] index_x_q,
  output logic [7:0] index_y_q,
  output logic [15:0] program_counter_q,
  output logic [7:0] condition_flags_q,
  output logic [15:0] stack_pointer_q,
  output logic busy_q
);
  // no bus port
  // Registers are reached only through request codes; there is no address decoder
  crs_stack_if stk ();
  crs_pkg::crs_state_type state_q;
  crs_pkg::crs_seq_type kind_q;
  crs_pkg::crs_item_type single_q;
  crs_pkg::crs_item_type cur_item;
  crs_pkg::crs_item_type op_item;
  logic [2:0] step_q;
  logic [2:0] last_step;
  logic [15:0] target_q;
  logic [1:0] level_q;
  logic prefix_q;
  logic take;
  logic push_done;
  logic pop_wr;
  logic [7:0] sp_low;
  logic [7:0] push_byte;

  // PC low first
  // Item at a given step of a frame; pop walks the same table backwards
  function automatic crs_pkg::crs_item_type item_at(input crs_pkg::crs_seq_type kind, input logic [2:0] step,
                                                     input crs_pkg::crs_item_type single);
    crs_pkg::crs_item_type item;
    item = single;
    case (kind)
      crs_pkg::SEQ_INT: begin
        case (step)
          3'h0: item = crs_pkg::ITEM_PCL;
          3'h1: item = crs_pkg::ITEM_PCH;
          3'h2: item = crs_pkg::ITEM_X;
          3'h3: item = crs_pkg::ITEM_A;
          default: item = crs_pkg::ITEM_CC;
        endcase
      end
      crs_pkg::SEQ_CALL: item = (step == 3'h0) ? crs_pkg::ITEM_PCL : crs_pkg::ITEM_PCH;
      default: item = single;
    endcase
    return item;
  endfunction

  // Requests are taken only while no stack frame is in flight
  assign take = op_valid && (state_q == crs_pkg::ST_IDLE);
  assign sp_low = stack_pointer_q[7:0];
  assign cur_item = item_at(kind_q, step_q, single_q);
  assign last_step = (kind_q == crs_pkg::SEQ_INT) ? crs_pkg::INT_LAST :
                     (kind_q == crs_pkg::SEQ_CALL) ? crs_pkg::CALL_LAST : crs_pkg::ONE_LAST;
  assign push_done = (state_q == crs_pkg::ST_PUSH) && (step_q == last_step);
  assign pop_wr = (state_q == crs_pkg::ST_POP_WR);
  assign op_item = (op_data[2:0] == crs_pkg::ITEM_X && prefix_q) ? crs_pkg::ITEM_Y
                   : crs_pkg::crs_item_type'(op_data[2:0]);

  // Byte to store for the current push step
  always_comb begin
    case (cur_item)
      crs_pkg::ITEM_PCL: push_byte = program_counter_q[7:0];
      crs_pkg::ITEM_PCH: push_byte = program_counter_q[15:8];
      crs_pkg::ITEM_X: push_byte = index_x_q;
      crs_pkg::ITEM_A: push_byte = accumulator_q;
      crs_pkg::ITEM_CC: push_byte = condition_flags_q;
      default: push_byte = index_y_q;
    endcase
  end

  // write at pointer, read one above
  assign stk.wr_en = (state_q == crs_pkg::ST_PUSH);
  assign stk.rd_en = (state_q == crs_pkg::ST_POP_RD);
  assign stk.addr = stk.wr_en ? sp_low : 8'(sp_low + crs_pkg::SP_STEP);
  assign stk.wr_data = push_byte;

  crs_stack_mem u_mem (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .stk(stk)
  );

  // Frame sequencer; one byte pushed per cycle, two cycles per popped byte
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= crs_pkg::ST_IDLE;
      kind_q <= crs_pkg::SEQ_ONE;
      single_q <= crs_pkg::ITEM_A;
      step_q <= 3'h0;
      target_q <= crs_pkg::PC_RESET;
      level_q <= crs_pkg::PRIO_LEVEL3;
      busy_q <= 1'b0;
    end else begin
      case (state_q)
        crs_pkg::ST_IDLE: begin
          target_q <= op_addr;
          level_q <= int_level;
          single_q <= op_item;
          if (take) begin
            case (op_code)
              crs_pkg::OP_PUSH: begin
                kind_q <= crs_pkg::SEQ_ONE;
                step_q <= 3'h0;
                state_q <= crs_pkg::ST_PUSH;
                busy_q <= 1'b1;
              end
              crs_pkg::OP_CALL, crs_pkg::OP_INT: begin
                kind_q <= (op_code == crs_pkg::OP_INT) ? crs_pkg::SEQ_INT : crs_pkg::SEQ_CALL;
                step_q <= 3'h0;
                state_q <= crs_pkg::ST_PUSH;
                busy_q <= 1'b1;
              end
              crs_pkg::OP_POP: begin
                kind_q <= crs_pkg::SEQ_ONE;
                step_q <= crs_pkg::ONE_LAST;
                state_q <= crs_pkg::ST_POP_RD;
                busy_q <= 1'b1;
              end
              crs_pkg::OP_RET, crs_pkg::OP_INTERRUPT_RETURN: begin
                kind_q <= (op_code == crs_pkg::OP_INTERRUPT_RETURN) ? crs_pkg::SEQ_INT : crs_pkg::SEQ_CALL;
                step_q <= (op_code == crs_pkg::OP_INTERRUPT_RETURN) ? crs_pkg::INT_LAST : crs_pkg::CALL_LAST;
                state_q <= crs_pkg::ST_POP_RD;
                busy_q <= 1'b1;
              end
              default: state_q <= crs_pkg::ST_IDLE;
            endcase
          end
        end
        crs_pkg::ST_PUSH: begin
          if (push_done) begin
            state_q <= crs_pkg::ST_IDLE;
            busy_q <= 1'b0;
          end else begin
            step_q <= 3'(step_q + crs_pkg::STEP_ONE);
          end
        end
        crs_pkg::ST_POP_RD: state_q <= crs_pkg::ST_POP_WR;
        default: begin
          if (step_q == 3'h0) begin
            state_q <= crs_pkg::ST_IDLE;
            busy_q <= 1'b0;
          end else begin
            step_q <= 3'(step_q - crs_pkg::STEP_ONE);
            state_q <= crs_pkg::ST_POP_RD;
          end
        end
      endcase
    end
  end

  // Prefix lasts for exactly the next accepted request
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prefix_q <= 1'b0;
    end else if (take) begin
      prefix_q <= (op_code == crs_pkg::OP_PREFIX);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      accumulator_q <= crs_pkg::BYTE_ZERO;
    end else if (take && op_code == crs_pkg::OP_LOAD_A) begin
      accumulator_q <= op_data;
    end else if (take && op_code == crs_pkg::OP_ALU && !op_data[0]) begin
      accumulator_q <= alu_result;
    end else if (pop_wr && cur_item == crs_pkg::ITEM_A) begin
      accumulator_q <= stk.rd_data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      index_x_q <= crs_pkg::BYTE_ZERO;
      index_y_q <= crs_pkg::BYTE_ZERO;
    end else if (take && (op_code == crs_pkg::OP_LOAD_IDX || (op_code == crs_pkg::OP_ALU && op_data[0]))) begin
      if (prefix_q) begin
        index_y_q <= (op_code == crs_pkg::OP_ALU) ? alu_result : op_data;
      end else begin
        index_x_q <= (op_code == crs_pkg::OP_ALU) ? alu_result : op_data;
      end
    end else if (pop_wr && cur_item == crs_pkg::ITEM_X) begin
      index_x_q <= stk.rd_data;
    end else if (pop_wr && cur_item == crs_pkg::ITEM_Y) begin
      // only a single pop reaches Y
      index_y_q <= stk.rd_data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      program_counter_q <= crs_pkg::PC_RESET;
    end else if (take && op_code == crs_pkg::OP_JUMP) begin
      program_counter_q <= op_addr;
    end else if (take && op_code == crs_pkg::OP_PC_INC) begin
      program_counter_q <= 16'(program_counter_q + crs_pkg::PC_STEP);
    end else if (push_done && kind_q != crs_pkg::SEQ_ONE) begin
      program_counter_q <= target_q;
    end else if (pop_wr && cur_item == crs_pkg::ITEM_PCL) begin
      program_counter_q[7:0] <= stk.rd_data;
    end else if (pop_wr && cur_item == crs_pkg::ITEM_PCH) begin
      program_counter_q[15:8] <= stk.rd_data;
    end
  end

  // Condition flags; reserved bits 7:6 always read zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      condition_flags_q <= crs_pkg::FLAGS_RESET;
    end else if (take) begin
      case (op_code)
        crs_pkg::OP_ALU: begin
          condition_flags_q[crs_pkg::BIT_N] <= alu_result[crs_pkg::BIT_SIGN];
          condition_flags_q[crs_pkg::BIT_Z] <= (alu_result == crs_pkg::BYTE_ZERO);
          // carry from arithmetic, shift, bit test
          if (alu_carry_en) begin
            condition_flags_q[crs_pkg::BIT_C] <= alu_carry;
          end
          if (alu_half_en) begin
            condition_flags_q[crs_pkg::BIT_H] <= alu_half;
          end
        end
        crs_pkg::OP_SET_C: condition_flags_q[crs_pkg::BIT_C] <= 1'b1;
        crs_pkg::OP_CLR_C: condition_flags_q[crs_pkg::BIT_C] <= 1'b0;
        crs_pkg::OP_FLAG_WR: begin
          if (op_data[2:0] <= 3'(crs_pkg::BIT_PHI)) begin
            condition_flags_q[op_data[2:0]] <= op_data[3];
          end
        end
        crs_pkg::OP_MASK_SET: {condition_flags_q[crs_pkg::BIT_PHI], condition_flags_q[crs_pkg::BIT_PLO]}
          <= crs_pkg::PRIO_LEVEL3;
        crs_pkg::OP_MASK_RST, crs_pkg::OP_WAIT: {condition_flags_q[crs_pkg::BIT_PHI],
          condition_flags_q[crs_pkg::BIT_PLO]} <= crs_pkg::PRIO_LEVEL0;
        default: condition_flags_q <= condition_flags_q;
      endcase
    end else if (push_done && kind_q == crs_pkg::SEQ_INT) begin
      // load serviced level after flags are saved
      {condition_flags_q[crs_pkg::BIT_PHI], condition_flags_q[crs_pkg::BIT_PLO]} <= level_q;
    end else if (pop_wr && cur_item == crs_pkg::ITEM_CC) begin
      condition_flags_q <= stk.rd_data & crs_pkg::FLAGS_MASK;
    end
  end

  // upper byte held fixed; low byte wraps
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stack_pointer_q <= {crs_pkg::STACK_HIGH, crs_pkg::SP_RESET_LOW};
    end else begin
      stack_pointer_q[15:8] <= crs_pkg::STACK_HIGH;
      if (take && op_code == crs_pkg::OP_RSP) begin
        stack_pointer_q[7:0] <= crs_pkg::SP_RESET_LOW;
      end else if (take && op_code == crs_pkg::OP_LD_SP) begin
        stack_pointer_q[7:0] <= op_data;
      end else if (state_q == crs_pkg::ST_PUSH) begin
        stack_pointer_q[7:0] <= 8'(sp_low - crs_pkg::SP_STEP);
      end else if (state_q == crs_pkg::ST_POP_RD) begin
        stack_pointer_q[7:0] <= 8'(sp_low + crs_pkg::SP_STEP);
      end
    end
  end

  // Checks on stack framing and flag updates
  sp_rsp_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    take && op_code == crs_pkg::OP_RSP |=> stack_pointer_q[7:0] == crs_pkg::SP_RESET_LOW)
    else $error("stack reset op did not set pointer to top");
  sp_push_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    stk.wr_en |-> stk.addr == sp_low ##1 sp_low == 8'($past(sp_low) - 8'h01))
    else $error("push did not store at pointer then decrement");
  push_wrap_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    stk.wr_en && sp_low == 8'h00 |=> sp_low == 8'hFF)
    else $error("pointer did not wrap on push below bottom");
  int_frame_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    take && op_code == crs_pkg::OP_INT |-> ##6 sp_low == 8'($past(sp_low, 6) - 8'h05) && !busy_q)
    else $error("interrupt frame not five bytes");
  call_frame_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    take && op_code == crs_pkg::OP_CALL |-> ##3 sp_low == 8'($past(sp_low, 3) - 8'h02))
    else $error("call frame not two bytes");
  first_pcl_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(busy_q) && state_q == crs_pkg::ST_PUSH && kind_q == crs_pkg::SEQ_INT
    |-> stk.wr_data == program_counter_q[7:0] ##1 stk.wr_data == program_counter_q[15:8])
    else $error("interrupt frame does not start with PC low then high");
  y_kept_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_q != crs_pkg::ST_IDLE && kind_q == crs_pkg::SEQ_INT |=> $stable(index_y_q))
    else $error("second index changed during interrupt frame");
  half_carry_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    take && op_code == crs_pkg::OP_ALU && alu_half_en |=> condition_flags_q[crs_pkg::BIT_H] == $past(alu_half))
    else $error("half carry not taken from adder");
  sign_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    take && op_code == crs_pkg::OP_ALU |=> condition_flags_q[crs_pkg::BIT_N] == $past(alu_result[7])
    && condition_flags_q[crs_pkg::BIT_Z] == ($past(alu_result) == 8'h00))
    else $error("sign or zero flag wrong after result");
  carry_force_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    take && op_code == crs_pkg::OP_SET_C |=> condition_flags_q[crs_pkg::BIT_C])
    else $error("set carry op left carry clear");
  prio_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    push_done && kind_q == crs_pkg::SEQ_INT
    |=> {condition_flags_q[crs_pkg::BIT_PHI], condition_flags_q[crs_pkg::BIT_PLO]} == $past(level_q))
    else $error("priority not loaded on interrupt entry");
  mask_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    take && op_code == crs_pkg::OP_MASK_SET
    |=> {condition_flags_q[crs_pkg::BIT_PHI], condition_flags_q[crs_pkg::BIT_PLO]} == 2'h3)
    else $error("mask set did not select level three");
  cov_int_c: cover property (@(posedge clk_sys) disable iff (!reset_n) push_done && kind_q == crs_pkg::SEQ_INT);
  cov_interrupt_return_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
    pop_wr && kind_q == crs_pkg::SEQ_INT && step_q == 3'h0);
  cov_wrap_c: cover property (@(posedge clk_sys) disable iff (!reset_n) stk.wr_en && sp_low == 8'h00);
  cov_prefix_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
    prefix_q && take && op_code == crs_pkg::OP_LOAD_IDX);
endmodule

// file: tb/tb.sv
// Self-checking bench for the core register set
`timescale 1ns/1ns
module tb;
  typedef struct packed {logic [7:0] a, x, y, cc, cm; logic [15:0] pc, sp;} crs_exp_type;
  logic clk_sys, reset_n, op_valid, alu_carry, alu_half, alu_carry_en, alu_half_en;
  crs_pkg::crs_op_type op_code;
  logic [7:0] op_data, alu_result, accumulator_q, index_x_q, index_y_q, condition_flags_q;
  logic [15:0] op_addr, program_counter_q, stack_pointer_q;
  logic [1:0] int_level;
  logic busy_q, ghost, pre;
  logic [7:0] ea, ex, ey, ecc, esp, tmp;
  logic [7:0] mem [256];
  logic [15:0] epc;
  crs_exp_type exp_q[$];
  int failures = 0, n_checks = 0, n, k;
  event chk_ev;
  crs_core_regs uut (.clk_sys(clk_sys), .reset_n(reset_n), .op_valid(op_valid), .op_code(op_code),
    .op_data(op_data), .op_addr(op_addr), .alu_result(alu_result), .alu_carry(alu_carry),
    .alu_half(alu_half), .alu_carry_en(alu_carry_en), .alu_half_en(alu_half_en),
    .int_level(int_level), .accumulator_q(accumulator_q), .index_x_q(index_x_q),
    .index_y_q(index_y_q), .program_counter_q(program_counter_q),
    .condition_flags_q(condition_flags_q), .stack_pointer_q(stack_pointer_q), .busy_q(busy_q));
  // Free-running core clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Files the model state as the next expected result
  task automatic note(input logic [7:0] cm);
    exp_q.push_back({ea, ex, ey, ecc, cm, epc, crs_pkg::STACK_HIGH, esp});
    -> chk_ev;
  endtask
  // Stack model: write then step down, step up then read
  task automatic mpu(input logic [7:0] v);
    mem[esp] = v;
    esp = esp - 8'h01;
  endtask
  task automatic mpo(output logic [7:0] v);
    esp = esp + 8'h01;
    v = mem[esp];
  endtask
  // One request; optional second strobe while busy must be dropped
  task automatic op(input crs_pkg::crs_op_type c, input logic [7:0] d, input logic [15:0] ad);
    logic [7:0] cm;
    int i;
    cm = 8'hFF;
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_code <= c;
    op_data <= d;
    op_addr <= ad;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    // Busy must rise just after the taking edge for stack frames only
    #1;
    cmp("busy", {15'h0000, c inside {crs_pkg::OP_PUSH, crs_pkg::OP_POP, crs_pkg::OP_CALL, crs_pkg::OP_RET,
      crs_pkg::OP_INT, crs_pkg::OP_INTERRUPT_RETURN}}, {15'h0000, busy_q});
    @(posedge clk_sys);
    op_valid <= ghost;
    op_code <= crs_pkg::OP_JUMP;
    op_addr <= 16'hBEEF;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    for (i = 0; i < 24 && busy_q !== 1'b0; i++) @(posedge clk_sys);
    if (busy_q !== 1'b0) begin
      failures++;
      end_of_test();
    end
    @(posedge clk_sys);
    case (c)
      crs_pkg::OP_LOAD_A: ea = d;
      crs_pkg::OP_LOAD_IDX: if (pre) ey = d; else ex = d;
      crs_pkg::OP_ALU: begin
        if (!d[0]) ea = alu_result; else if (pre) ey = alu_result; else ex = alu_result;
        ecc[crs_pkg::BIT_N] = alu_result[7];
        ecc[crs_pkg::BIT_Z] = (alu_result == 8'h00);
        if (alu_carry_en) ecc[crs_pkg::BIT_C] = alu_carry;
        if (alu_half_en) ecc[crs_pkg::BIT_H] = alu_half;
      end
      crs_pkg::OP_SET_C: ecc[crs_pkg::BIT_C] = 1'b1;
      crs_pkg::OP_CLR_C: ecc[crs_pkg::BIT_C] = 1'b0;
      crs_pkg::OP_FLAG_WR: if (d[2:0] < 3'h6) ecc[d[2:0]] = d[3];
      crs_pkg::OP_MASK_SET: {ecc[5], ecc[3]} = crs_pkg::PRIO_LEVEL3;
      crs_pkg::OP_MASK_RST, crs_pkg::OP_WAIT: {ecc[5], ecc[3]} = crs_pkg::PRIO_LEVEL0;
      crs_pkg::OP_PUSH: mpu(d[2:0] == 3'h0 ? epc[7:0] : d[2:0] == 3'h1 ? epc[15:8] :
        d[2:0] == 3'h2 ? ex : d[2:0] == 3'h3 ? ea : d[2:0] == 3'h4 ? ecc : ey);
      crs_pkg::OP_POP: begin
        mpo(tmp);
        case (d[2:0])
          3'h0: epc[7:0] = tmp;
          3'h1: epc[15:8] = tmp;
          3'h2: ex = tmp;
          3'h3: ea = tmp;
          3'h4: ecc = tmp & crs_pkg::FLAGS_MASK;
          default: ey = tmp;
        endcase
      end
      crs_pkg::OP_CALL, crs_pkg::OP_INT: begin
        mpu(epc[7:0]);
        mpu(epc[15:8]);
        if (c == crs_pkg::OP_INT) begin
          mpu(ex);
          mpu(ea);
          mpu(ecc);
          {ecc[5], ecc[3]} = int_level;
        end
        epc = ad;
      end
      crs_pkg::OP_RET, crs_pkg::OP_INTERRUPT_RETURN: begin
        if (c == crs_pkg::OP_INTERRUPT_RETURN) begin
          mpo(tmp);
          ecc = tmp & crs_pkg::FLAGS_MASK;
          mpo(ea);
          mpo(ex);
        end
        mpo(epc[15:8]);
        mpo(epc[7:0]);
      end
      crs_pkg::OP_RSP: esp = crs_pkg::SP_RESET_LOW;
      crs_pkg::OP_LD_SP: esp = d;
      crs_pkg::OP_JUMP: epc = ad;
      crs_pkg::OP_PC_INC: epc = epc + 16'h0001;
      default: ;
    endcase
    // Loads and plain pops may or may not touch N and Z, so those are masked
    if (c inside {crs_pkg::OP_LOAD_A, crs_pkg::OP_LOAD_IDX, crs_pkg::OP_LD_SP, crs_pkg::OP_POP}
      && !(c == crs_pkg::OP_POP && d[2:0] == 3'h4)) cm = 8'hF9;
    pre = (c == crs_pkg::OP_PREFIX);
    note(cm);
  endtask
  // Takes the oldest note whenever a result settles
  initial begin : monitor
    crs_exp_type e;
    forever begin
      @(chk_ev);
      e = exp_q.pop_front();
      cmp("accumulator", {8'h00, e.a}, {8'h00, accumulator_q});
      cmp("index_x", {8'h00, e.x}, {8'h00, index_x_q});
      cmp("index_y", {8'h00, e.y}, {8'h00, index_y_q});
      cmp("program_counter", e.pc, program_counter_q);
      cmp("condition_flags", {8'h00, e.cc & e.cm}, {8'h00, condition_flags_q & e.cm});
      cmp("stack_pointer", e.sp, stack_pointer_q);
    end
  end
  // Main sequence
  initial begin
    reset_n = 1'b0;
    {op_valid, alu_carry, alu_half, alu_carry_en, alu_half_en, ghost, pre} = 7'h00;
    op_code = crs_pkg::OP_NOP;
    {op_data, alu_result, op_addr, int_level} = 34'h000000000;
    {ea, ex, ey, epc} = 40'h0000000000;
    ecc = crs_pkg::FLAGS_RESET;
    esp = crs_pkg::SP_RESET_LOW;
    n = $urandom(78);
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    note(8'hFF);
    for (k = 0; k < 16; k++) begin
      @(posedge clk_sys);
      alu_result <= (k == 3) ? 8'h00 : (k == 5) ? 8'h80 : 8'($urandom);
      {alu_carry, alu_half, alu_carry_en, alu_half_en} <= 4'($urandom);
      if (k % 4 == 1) op(crs_pkg::OP_PREFIX, 8'h00, 16'h0000);
      op(crs_pkg::OP_ALU, 8'($urandom), 16'h0000);
    end
    op(crs_pkg::OP_SET_C, 8'h00, 16'h0000);
    op(crs_pkg::OP_CLR_C, 8'h00, 16'h0000);
    for (k = 0; k < 16; k++) op(crs_pkg::OP_FLAG_WR, 8'(k), 16'h0000);
    op(crs_pkg::OP_MASK_SET, 8'h00, 16'h0000);
    op(crs_pkg::OP_WAIT, 8'h00, 16'h0000);
    op(crs_pkg::OP_MASK_SET, 8'h00, 16'h0000);
    op(crs_pkg::OP_MASK_RST, 8'h00, 16'h0000);
    op(crs_pkg::OP_LOAD_A, 8'($urandom), 16'h0000);
    op(crs_pkg::OP_LOAD_IDX, 8'($urandom), 16'h0000);
    op(crs_pkg::OP_PREFIX, 8'h00, 16'h0000);
    op(crs_pkg::OP_LOAD_IDX, 8'($urandom), 16'h0000);
    op(crs_pkg::OP_JUMP, 8'h00, 16'($urandom));
    op(crs_pkg::OP_PC_INC, 8'h00, 16'h0000);
    op(crs_pkg::OP_LD_SP, 8'($urandom), 16'h0000);
    for (k = 0; k < 6; k++) op(crs_pkg::OP_PUSH, 8'(k), 16'h0000);
    for (k = 5; k >= 0; k--) op(crs_pkg::OP_POP, 8'(k), 16'h0000);
    op(crs_pkg::OP_CALL, 8'h00, 16'($urandom));
    op(crs_pkg::OP_RET, 8'h00, 16'h0000);
    // each source level, frame spilling over the low limit at levels 2 and 3
    for (k = 0; k < 4; k++) begin
      ghost = (k == 0);
      @(posedge clk_sys);
      int_level <= 2'(k);
      if (k == 2) op(crs_pkg::OP_LD_SP, 8'h02, 16'h0000);
      op(crs_pkg::OP_INT, 8'h00, 16'($urandom));
      ghost = 1'b0;
      op(crs_pkg::OP_INTERRUPT_RETURN, 8'h00, 16'h0000);
    end
    op(crs_pkg::OP_LD_SP, 8'h00, 16'h0000);
    op(crs_pkg::OP_PUSH, 8'h03, 16'h0000);
    op(crs_pkg::OP_POP, 8'h03, 16'h0000);
    op(crs_pkg::OP_RSP, 8'h00, 16'h0000);
    end_of_test();
  end
endmodule
